// ---- inc/tzm_defines.svh ----
// Register offsets, field positions, reset values and fixed figures
// for the battery temperature zone monitor.
// Assumes an APB slave with 32-bit data and byte addresses.
`ifndef TZM_DEFINES_SVH
`define TZM_DEFINES_SVH

// Register byte offsets
`define TZM_CTRL_OFS       8'h00
`define TZM_TRIP_OFS       8'h04
`define TZM_CV_OFS         8'h08
`define TZM_CC_OFS         8'h0C
`define TZM_MOD_OFS        8'h10
`define TZM_RAIL_OFS       8'h14
`define TZM_MUX_OFS        8'h18
`define TZM_STATUS_OFS     8'h1C
`define TZM_FLAG_OFS       8'h20
`define TZM_MASK_OFS       8'h24

// Field positions
`define TZM_CTRL_EN_BIT    0
`define TZM_TRIP_HOT_LSB   0
`define TZM_TRIP_WARM_LSB  2
`define TZM_TRIP_COOL_LSB  4
`define TZM_TRIP_COLD_LSB  6
`define TZM_MOD_V_LSB      0
`define TZM_MOD_I_LSB      8
`define TZM_ST_FAULT_BIT   4
`define TZM_ST_MOD_BIT     5
`define TZM_ST_BIAS_BIT    6
`define TZM_ST_CHARGE_INPUT_BIT   7
`define TZM_ST_RESUME_LSB  8
`define TZM_FLAG_ZONE_BIT  0
`define TZM_FLAG_RAIL_BIT  1

// Reset values
`define TZM_CV_RST         6'h10
`define TZM_CC_RST         6'h00
`define TZM_MOD_RST        6'h00
`define TZM_RAIL_RST       6'h10
`define TZM_TRIP_RST       8'h00
`define TZM_MUX_RST        4'h0
`define TZM_MASK_RST       2'h0

// Voltage code scales in millivolts
`define TZM_CV_BASE_MV     3600
`define TZM_CV_STEP_MV     25
`define TZM_RAIL_BASE_MV   4100
`define TZM_RAIL_MARGIN_MV 200

// Analog multiplexer channels that need the thermistor biased
`define TZM_MUX_SENSOR     4'h7
`define TZM_MUX_BIAS       4'h8

// Twelve selectable trip voltages in millivolts, coldest first
`define TZM_TRIP_MV_0      11'd1024
`define TZM_TRIP_MV_1      11'd976
`define TZM_TRIP_MV_2      11'd923
`define TZM_TRIP_MV_3      11'd867
`define TZM_TRIP_MV_4      11'd807
`define TZM_TRIP_MV_5      11'd747
`define TZM_TRIP_MV_6      11'd511
`define TZM_TRIP_MV_7      11'd459
`define TZM_TRIP_MV_8      11'd411
`define TZM_TRIP_MV_9      11'd367
`define TZM_TRIP_MV_10     11'd327
`define TZM_TRIP_MV_11     11'd291

// First table index reachable by each 2-bit trip select
`define TZM_COLD_BASE_IDX  4'd0
`define TZM_COOL_BASE_IDX  4'd2
`define TZM_WARM_BASE_IDX  4'd6
`define TZM_HOT_BASE_IDX   4'd8

`endif

// ---- inc/tzm_pkg.sv ----
// Types shared by the temperature zone monitor files.
// Assumes tzm_defines.svh supplies all numeric constants.
package tzm_pkg;

   // Reported temperature zone
   typedef enum logic [2:0] {
      TZM_ZONE_DISABLED = 3'h0,
      TZM_ZONE_COLD     = 3'h1,
      TZM_ZONE_COOL     = 3'h2,
      TZM_ZONE_NORMAL   = 3'h3,
      TZM_ZONE_WARM     = 3'h4,
      TZM_ZONE_HOT      = 3'h5
   } tzm_zone_t;

   // Charging response state
   typedef enum logic [2:0] {
      TZM_ST_NORMAL   = 3'b001,
      TZM_ST_MODIFIED = 3'b010,
      TZM_ST_FAULT    = 3'b100
   } tzm_state_t;

   // Trip thresholds sent to the analog comparators, in millivolts
   typedef struct packed {
      logic [10:0] hotMv;
      logic [10:0] warmMv;
      logic [10:0] coolMv;
      logic [10:0] coldMv;
   } tzm_trip_t;

   // Setpoints handed to the charger regulation loop
   typedef struct packed {
      logic [5:0] voltageCode;
      logic [5:0] currentCode;
   } tzm_setpoint_t;

endpackage

// ---- tb/battery_temp_zone_monitor_tb.sv ----
// Self-checking bench for the temperature zone monitor.
// Assumes the APB map and zone codes of the design package.
`timescale 1ns/10ps
`include "tzm_defines.svh"
module battery_temp_zone_monitor_tb
   import tzm_pkg::*;
;
   logic          core_clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]    paddr;
   logic [31:0]   pwdata, prdata;
   logic [3:0]    tripCmpIn, chargerState, monitorSelect, resumeState;
   logic          chargeInputValid, sensorBiasEn, chargePause, timerHold;
   logic          modifiedActive, tempZoneIrq, railConfigErrorIrq;
   tzm_trip_t     tripLevels;
   tzm_setpoint_t setpoint;
   tzm_zone_t     zoneCmd;
   int            mismatches, testsRun;
   logic [10:0]   mv [12] = '{11'h400, 11'h3D0, 11'h39B, 11'h363, 11'h327,
      11'h2EB, 11'h1FF, 11'h1CB, 11'h19B, 11'h16F, 11'h147, 11'h123};

   tzm_monitor uut (.core_clk(core_clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tripCmpIn(tripCmpIn), .chargeInputValid(chargeInputValid),
      .chargerState(chargerState), .tripLevels(tripLevels),
      .setpoint(setpoint), .sensorBiasEn(sensorBiasEn),
      .monitorSelect(monitorSelect), .chargePause(chargePause),
      .timerHold(timerHold), .modifiedActive(modifiedActive),
      .resumeState(resumeState), .tempZoneIrq(tempZoneIrq),
      .railConfigErrorIrq(railConfigErrorIrq));
   tzm_ntc_model ntc (.zoneCmd(zoneCmd), .tripCmpIn(tripCmpIn));

   task automatic reportAndStop;
      $display("Checks %0d, mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic cmp(input logic [43:0] got, exp, input string m);
      testsRun++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic er);
      int n;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'h1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'h1);
      cmp(n < 20, 1'h1, "no answer");
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      xfer(1'h1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] msk, e,
      input string m);
      logic [31:0] q;
      logic        r;
      xfer(1'h0, a, 32'h0, q, r);
      cmp(q & msk, e, m);
   endtask

   task automatic tReset;
      logic [31:0] q;
      logic        e;
      rd(`TZM_CV_OFS, 32'hFF, 32'h10, "cv reset");
      rd(`TZM_RAIL_OFS, 32'hFF, 32'h10, "rail reset");
      rd(`TZM_STATUS_OFS, 32'h7, 32'h0, "zone reset");
      xfer(1'h0, 8'h40, 32'h0, q, e);
      cmp({e, q}, 33'h1_0000_0000, "unmapped");
      for (int s = 0; s < 4; s++)
      begin
         wr(`TZM_TRIP_OFS, {4{2'(s)}});
         @(posedge core_clk);
         cmp(tripLevels, {mv[8+s], mv[6+s], mv[2+s], mv[s]}, "trip");
      end
   endtask

   task automatic tZones;
      tzm_zone_t   z [5] = '{TZM_ZONE_COLD, TZM_ZONE_COOL, TZM_ZONE_NORMAL,
                             TZM_ZONE_WARM, TZM_ZONE_HOT};
      logic        f, m;
      wr(`TZM_MUX_OFS, 32'h7);
      wr(`TZM_MOD_OFS, 32'h0A05);
      wr(`TZM_CC_OFS, 32'h20);
      wr(`TZM_MASK_OFS, 32'h1);
      wr(`TZM_CTRL_OFS, 32'h1);
      repeat (8) @(posedge core_clk);
      wr(`TZM_FLAG_OFS, 32'h1);
      for (int i = 0; i < 5; i++)
      begin
         zoneCmd <= z[i];
         chargerState <= 4'(i + 2);
         repeat (8) @(posedge core_clk);
         f = z[i] inside {TZM_ZONE_HOT, TZM_ZONE_COLD};
         m = z[i] inside {TZM_ZONE_WARM, TZM_ZONE_COOL};
         rd(`TZM_STATUS_OFS, 32'h7, z[i], "zone");
         cmp(chargePause, f, "pause");
         cmp(modifiedActive, m, "modified");
         cmp(setpoint, f ? 12'h400 : m ? 12'h14A : 12'h420, "setp");
         cmp(tempZoneIrq, 1'h1, "zone irq");
         if (f)
            cmp(resumeState, 4'(i + 2), "resume");
         wr(`TZM_FLAG_OFS, 32'h1);
      end
      wr(`TZM_CTRL_OFS, 32'h0);
      repeat (8) @(posedge core_clk);
      cmp({chargePause, modifiedActive, tempZoneIrq}, 3'h1, "off");
      cmp({sensorBiasEn, monitorSelect}, 5'h17, "mux bias");
      wr(`TZM_MUX_OFS, 32'h0);
      repeat (3) @(posedge core_clk);
      cmp(sensorBiasEn, 1'h0, "bias idle");
      wr(`TZM_CTRL_OFS, 32'h1);
      repeat (3) @(posedge core_clk);
      cmp(sensorBiasEn, 1'h1, "bias on");
   endtask

   task automatic tMargin;
      wr(`TZM_MASK_OFS, 32'h2);
      wr(`TZM_CV_OFS, 32'h1C);
      repeat (3) @(posedge core_clk);
      rd(`TZM_CV_OFS, 32'hFF, 32'h1C, "cv edge");
      cmp(railConfigErrorIrq, 1'h0, "rail quiet");
      wr(`TZM_CV_OFS, 32'h3F);
      repeat (3) @(posedge core_clk);
      rd(`TZM_CV_OFS, 32'hFF, 32'h1C, "cv fixed");
      cmp(railConfigErrorIrq, 1'h1, "rail irq");
   endtask

   initial
   begin
      core_clk = 1'h0;
      forever #50 core_clk = ~core_clk;
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      reportAndStop();
   end

   initial
   begin
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      chargeInputValid = 1'h1;
      chargerState = 4'h0;
      zoneCmd = TZM_ZONE_NORMAL;
      repeat (16) @(posedge core_clk);
      nrst <= 1'h1;
      @(posedge core_clk);
      tReset();
      tZones();
      tMargin();
      reportAndStop();
   end
endmodule

// ---- tb/tzm_monitor_chk.sv ----
// Port-level checks on the temperature zone monitor.
// Assumes one clock domain and the tzm_monitor port names.
`timescale 1ns/10ps
module tzm_monitor_chk
   import tzm_pkg::*;
(
   input wire logic          core_clk,
   input wire logic          nrst,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire logic [3:0]    chargerState,
   input wire tzm_trip_t     tripLevels,
   input wire tzm_setpoint_t setpoint,
   input wire logic          sensorBiasEn,
   input wire logic [3:0]    monitorSelect,
   input wire logic          chargePause,
   input wire logic          timerHold,
   input wire logic          modifiedActive,
   input wire logic [3:0]    resumeState
);
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   sequence sAccess;
      psel && penable && !pready;
   endsequence
   sequence sFaultHeld;
      chargePause [*2];
   endsequence
   AST_APB_WAIT: assert property (sAccess |=> pready)
      else $error("answer missing after one wait state");
   AST_APB_PULSE: assert property (pready |=> !pready)
      else $error("ready held too long");
   AST_APB_IDLE: assert property (!pready |-> prdata == 32'h0 && !pslverr)
      else $error("read data or error outside answer");
   AST_TRIP_TABLE: assert property ($past(nrst) |->
      tripLevels.hotMv inside {11'h19B, 11'h16F, 11'h147, 11'h123} &&
      tripLevels.coldMv inside {11'h400, 11'h3D0, 11'h39B, 11'h363})
      else $error("trip level outside table");
   AST_EXCLUSIVE: assert property (!(chargePause && modifiedActive))
      else $error("fault and modified state together");
   AST_TIMER_HOLD: assert property (timerHold == chargePause)
      else $error("timer hold differs from pause");
   AST_RESUME_CAPTURE: assert property ($rose(chargePause) |->
      resumeState == $past(chargerState))
      else $error("resume state not captured");
   AST_RESUME_HOLD: assert property (chargePause && $past(chargePause)
      |-> $stable(resumeState))
      else $error("resume state changed in fault");
   AST_FAULT_CURRENT: assert property (sFaultHeld |->
      setpoint.currentCode == 6'h00)
      else $error("current not zero in fault");
   AST_BIAS_MUX: assert property (
      (monitorSelect inside {4'h7, 4'h8}) [*2] |-> sensorBiasEn)
      else $error("bias off while mux reads thermistor");
endmodule

bind tzm_monitor tzm_monitor_chk chk (.core_clk(core_clk), .nrst(nrst),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .chargerState(chargerState),
   .tripLevels(tripLevels), .setpoint(setpoint),
   .sensorBiasEn(sensorBiasEn), .monitorSelect(monitorSelect),
   .chargePause(chargePause), .timerHold(timerHold),
   .modifiedActive(modifiedActive), .resumeState(resumeState));

// ---- tb/tzm_ntc_model.sv ----
// Thermistor network as seen through the four trip comparators.
// Assumes the bench picks the zone; comparators switch ideally.
`timescale 1ns/10ps
module tzm_ntc_model
   import tzm_pkg::*;
(
   input  wire tzm_zone_t zoneCmd,
   output logic [3:0]     tripCmpIn
);
   always_comb
   begin
      case (zoneCmd)
         TZM_ZONE_HOT:  tripCmpIn = 4'hC;
         TZM_ZONE_WARM: tripCmpIn = 4'h4;
         TZM_ZONE_COOL: tripCmpIn = 4'h2;
         TZM_ZONE_COLD: tripCmpIn = 4'h3;
         default:       tripCmpIn = 4'h0;
      endcase
   end
endmodule

// ---- verilog/tzm_monitor.sv ----
// Battery temperature zone monitor with APB register access.
// Assumes analog comparators report the thermistor against the four
// trip levels, and the charger core consumes pause and setpoints.
`timescale 1ns/10ps
`include "tzm_defines.svh"

// Functional notes
// - Lower charge voltage code until rail sits 200mV above it.
// - Raise rail configuration error interrupt on every automatic rewrite.
// - With enable set, track zone continuously from trip comparators.
// - Between cool and warm, use normal setpoints, no modified state.
// - In warm or cool zone, enter modified state, use 6-bit setpoints.
// - Above hot or below cold, pause charging in temperature fault.
// - Report zone in 3-bit field, interrupt on each change.
// - Enable cleared removes modified and fault responses entirely.
// - Each trip point has its own 2-bit select of four options.
// - Bias thermistor when charge input valid and enable set.
// - Also bias thermistor when mux selects sensor or bias pin.
// - Mux selection never affects comparators or zone response.
// - Trip voltages come from twelve fixed values, 1.024V to 0.291V.
// - After fault, charger returns to the state held before it.
// - Charger timers pause during fault and resume after.
// - Leave modified state on normal temperature or enable cleared.
module tzm_monitor
   import tzm_pkg::*;
#(
   parameter int ADDR_WIDTH = 8
)
(
   input  wire logic                  core_clk,
   input  wire logic                  nrst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_WIDTH-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [3:0]            tripCmpIn,
   input  wire logic                  chargeInputValid,
   input  wire logic [3:0]            chargerState,
   output tzm_trip_t                  tripLevels,
   output tzm_setpoint_t              setpoint,
   output logic                       sensorBiasEn,
   output logic [3:0]                 monitorSelect,
   output logic                       chargePause,
   output logic                       timerHold,
   output logic                       modifiedActive,
   output logic [3:0]                 resumeState,
   output logic                       tempZoneIrq,
   output logic                       railConfigErrorIrq
);

   localparam int HEADROOM_STEPS = (`TZM_RAIL_BASE_MV - `TZM_CV_BASE_MV
                                   - `TZM_RAIL_MARGIN_MV) / `TZM_CV_STEP_MV;

   // Software registers
   logic             thermistorEnable_reg;
   logic [7:0]       trip_reg;
   logic [5:0]       chargeVoltage_reg;
   logic [5:0]       chargeCurrent_reg;
   logic [5:0]       modVoltage_reg;
   logic [5:0]       modCurrent_reg;
   logic [5:0]       rail_reg;
   logic [3:0]       muxSel_reg;
   logic [1:0]       flag_reg;
   logic [1:0]       mask_reg;

   // Block state
   tzm_zone_t        zone_reg;
   tzm_zone_t        zone_next;
   tzm_state_t       state_reg;
   tzm_state_t       state_next;
   logic [3:0]       savedState_reg;

   // Bus helpers
   logic             accessPhase;
   logic             wrEn;
   logic             mapped;
   logic [31:0]      readMux;
   logic [31:0]      statusWord;

   // Synchronised comparator and input levels
   logic [3:0]       tripSync;
   logic             chgInSync;
   logic             beyondHot;
   logic             beyondWarm;
   logic             beyondCool;
   logic             beyondCold;

   // Rail margin check and zone change detect
   logic [6:0]       cvLimit;
   logic             cvTooHigh;
   logic             zoneChanged;

   tzm_sync
   #(
      .WIDTH (5)
   )
   u_inSync
   (
      .core_clk (core_clk),
      .nrst     (nrst),
      .asyncIn  ({chargeInputValid, tripCmpIn}),
      .syncOut  ({chgInSync, tripSync})
   );

   assign beyondCold = tripSync[0];
   assign beyondCool = tripSync[1];
   assign beyondWarm = tripSync[2];
   assign beyondHot  = tripSync[3];

   // ---------------- APB slave ----------------
   assign accessPhase = psel && penable;
   assign wrEn        = accessPhase && pready && pwrite;

   always_comb
   begin
      mapped = 1'b1;
      case (paddr)
         `TZM_CTRL_OFS,
         `TZM_TRIP_OFS,
         `TZM_CV_OFS,
         `TZM_CC_OFS,
         `TZM_MOD_OFS,
         `TZM_RAIL_OFS,
         `TZM_MUX_OFS,
         `TZM_STATUS_OFS,
         `TZM_FLAG_OFS,
         `TZM_MASK_OFS:
            mapped = 1'b1;
         default:
            mapped = 1'b0;
      endcase
   end

   always_comb
   begin
      statusWord = 32'h0000_0000;
      statusWord[2:0] = zone_reg;
      statusWord[`TZM_ST_FAULT_BIT] = (state_reg == TZM_ST_FAULT);
      statusWord[`TZM_ST_MOD_BIT] = (state_reg == TZM_ST_MODIFIED);
      statusWord[`TZM_ST_BIAS_BIT] = sensorBiasEn;
      statusWord[`TZM_ST_CHARGE_INPUT_BIT] = chgInSync;
      statusWord[`TZM_ST_RESUME_LSB +: 4] = savedState_reg;
   end

   always_comb
   begin
      readMux = 32'h0000_0000;
      case (paddr)
         `TZM_CTRL_OFS:
            readMux[`TZM_CTRL_EN_BIT] = thermistorEnable_reg;
         `TZM_TRIP_OFS:
            readMux[7:0] = trip_reg;
         `TZM_CV_OFS:
            readMux[5:0] = chargeVoltage_reg;
         `TZM_CC_OFS:
            readMux[5:0] = chargeCurrent_reg;
         `TZM_MOD_OFS:
         begin
            readMux[`TZM_MOD_V_LSB +: 6] = modVoltage_reg;
            readMux[`TZM_MOD_I_LSB +: 6] = modCurrent_reg;
         end
         `TZM_RAIL_OFS:
            readMux[5:0] = rail_reg;
         `TZM_MUX_OFS:
            readMux[3:0] = muxSel_reg;
         `TZM_STATUS_OFS:
            readMux = statusWord;
         `TZM_FLAG_OFS:
            readMux[1:0] = flag_reg;
         `TZM_MASK_OFS:
            readMux[1:0] = mask_reg;
         default:
            readMux = 32'h0000_0000;
      endcase
   end

   // One wait state: answer data is registered on the first access cycle
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (accessPhase && !pready)
      begin
         pready  <= 1'b1;
         pslverr <= !mapped;
         prdata  <= (!pwrite) ? readMux : 32'h0000_0000;
      end
      else
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end

   // Plain control registers
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         thermistorEnable_reg <= 1'b0;
         trip_reg             <= `TZM_TRIP_RST;
         chargeCurrent_reg    <= `TZM_CC_RST;
         modVoltage_reg       <= `TZM_MOD_RST;
         modCurrent_reg       <= `TZM_MOD_RST;
         rail_reg             <= `TZM_RAIL_RST;
         muxSel_reg           <= `TZM_MUX_RST;
         mask_reg             <= `TZM_MASK_RST;
      end
      else if (wrEn)
      begin
         case (paddr)
            `TZM_CTRL_OFS:
               thermistorEnable_reg <= pwdata[`TZM_CTRL_EN_BIT];
            `TZM_TRIP_OFS:
               trip_reg <= pwdata[7:0];
            `TZM_CC_OFS:
               chargeCurrent_reg <= pwdata[5:0];
            `TZM_MOD_OFS:
            begin
               modVoltage_reg <= pwdata[`TZM_MOD_V_LSB +: 6];
               modCurrent_reg <= pwdata[`TZM_MOD_I_LSB +: 6];
            end
            `TZM_RAIL_OFS:
               rail_reg <= pwdata[5:0];
            `TZM_MUX_OFS:
               muxSel_reg <= pwdata[3:0];
            `TZM_MASK_OFS:
               mask_reg <= pwdata[1:0];
            default:
               mask_reg <= mask_reg;
         endcase
      end
   end

   // ---------------- Rail margin enforcement ----------------
   assign cvLimit   = {1'b0, rail_reg} + 7'(HEADROOM_STEPS);
   assign cvTooHigh = ({1'b0, chargeVoltage_reg} > cvLimit);

   // clamp charge voltage code one cycle after a violation
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         chargeVoltage_reg <= `TZM_CV_RST;
      else if (wrEn && paddr == `TZM_CV_OFS)
         chargeVoltage_reg <= pwdata[5:0];
      else if (cvTooHigh)
         chargeVoltage_reg <= cvLimit[5:0];
   end

   // ---------------- Zone classification ----------------
   // zone tracked from comparators while enabled
   always_comb
   begin
      if (!thermistorEnable_reg)
         zone_next = TZM_ZONE_DISABLED;
      else if (beyondHot)
         zone_next = TZM_ZONE_HOT;
      else if (beyondCold)
         zone_next = TZM_ZONE_COLD;
      else if (beyondWarm)
         zone_next = TZM_ZONE_WARM;
      else if (beyondCool)
         zone_next = TZM_ZONE_COOL;
      else
         zone_next = TZM_ZONE_NORMAL;
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         zone_reg <= TZM_ZONE_DISABLED;
      else
         zone_reg <= zone_next;
   end

   assign zoneChanged = (zone_next != zone_reg);

   // ---------------- Response state machine ----------------
   always_comb
   begin
      case (zone_next)
         TZM_ZONE_HOT,
         TZM_ZONE_COLD:
            state_next = TZM_ST_FAULT;
         // warm or cool uses modified setpoints
         TZM_ZONE_WARM,
         TZM_ZONE_COOL:
            state_next = TZM_ST_MODIFIED;
         // disabled falls back to normal response
         TZM_ZONE_DISABLED:
            state_next = TZM_ST_NORMAL;
         default:
            state_next = TZM_ST_NORMAL;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         state_reg <= TZM_ST_NORMAL;
      else
         state_reg <= state_next;
   end

   // remember charger state on fault entry
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         savedState_reg <= 4'h0;
      else if (state_next == TZM_ST_FAULT && state_reg != TZM_ST_FAULT)
         savedState_reg <= chargerState;
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         chargePause    <= 1'b0;
         timerHold      <= 1'b0;
         modifiedActive <= 1'b0;
         resumeState    <= 4'h0;
      end
      else
      begin
         chargePause    <= (state_next == TZM_ST_FAULT);
         // timers frozen for the fault duration
         timerHold      <= (state_next == TZM_ST_FAULT);
         modifiedActive <= (state_next == TZM_ST_MODIFIED);
         resumeState    <= (state_next == TZM_ST_FAULT &&
                            state_reg != TZM_ST_FAULT) ?
                           chargerState : savedState_reg;
      end
   end

   // Setpoints follow the response state
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         setpoint <= '0;
      else if (state_reg == TZM_ST_MODIFIED)
      begin
         setpoint.voltageCode <= modVoltage_reg;
         setpoint.currentCode <= modCurrent_reg;
      end
      else if (state_reg == TZM_ST_FAULT)
      begin
         setpoint.voltageCode <= chargeVoltage_reg;
         setpoint.currentCode <= 6'h00;
      end
      else
      begin
         setpoint.voltageCode <= chargeVoltage_reg;
         setpoint.currentCode <= chargeCurrent_reg;
      end
   end

   // ---------------- Trip level selection ----------------
   function automatic logic [10:0] tripMv(input logic [3:0] idx);
      // fixed table of twelve trip voltages
      case (idx)
         4'd0:    tripMv = `TZM_TRIP_MV_0;
         4'd1:    tripMv = `TZM_TRIP_MV_1;
         4'd2:    tripMv = `TZM_TRIP_MV_2;
         4'd3:    tripMv = `TZM_TRIP_MV_3;
         4'd4:    tripMv = `TZM_TRIP_MV_4;
         4'd5:    tripMv = `TZM_TRIP_MV_5;
         4'd6:    tripMv = `TZM_TRIP_MV_6;
         4'd7:    tripMv = `TZM_TRIP_MV_7;
         4'd8:    tripMv = `TZM_TRIP_MV_8;
         4'd9:    tripMv = `TZM_TRIP_MV_9;
         4'd10:   tripMv = `TZM_TRIP_MV_10;
         default: tripMv = `TZM_TRIP_MV_11;
      endcase
   endfunction

   // each select picks one of four levels in its own range
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         tripLevels <= '0;
      else
      begin
         tripLevels.hotMv  <= tripMv(`TZM_HOT_BASE_IDX +
                              {2'b00, trip_reg[`TZM_TRIP_HOT_LSB +: 2]});
         tripLevels.warmMv <= tripMv(`TZM_WARM_BASE_IDX +
                              {2'b00, trip_reg[`TZM_TRIP_WARM_LSB +: 2]});
         tripLevels.coolMv <= tripMv(`TZM_COOL_BASE_IDX +
                              {2'b00, trip_reg[`TZM_TRIP_COOL_LSB +: 2]});
         tripLevels.coldMv <= tripMv(`TZM_COLD_BASE_IDX +
                              {2'b00, trip_reg[`TZM_TRIP_COLD_LSB +: 2]});
      end
   end

   // ---------------- Thermistor bias and monitor mux ----------------
   // mux select only feeds bias and output pin, not zone logic
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sensorBiasEn  <= 1'b0;
         monitorSelect <= `TZM_MUX_RST;
      end
      else
      begin
         sensorBiasEn  <= (chgInSync && thermistorEnable_reg) ||
                          (muxSel_reg == `TZM_MUX_SENSOR) ||
                          (muxSel_reg == `TZM_MUX_BIAS);
         monitorSelect <= muxSel_reg;
      end
   end

   // ---------------- Event flags ----------------
   // Set wins over a same-cycle write-one-to-clear
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         flag_reg <= 2'h0;
      else
      begin
         if (zoneChanged)
            flag_reg[`TZM_FLAG_ZONE_BIT] <= 1'b1;
         else if (wrEn && paddr == `TZM_FLAG_OFS &&
                  pwdata[`TZM_FLAG_ZONE_BIT])
            flag_reg[`TZM_FLAG_ZONE_BIT] <= 1'b0;
         if (cvTooHigh)
            flag_reg[`TZM_FLAG_RAIL_BIT] <= 1'b1;
         else if (wrEn && paddr == `TZM_FLAG_OFS &&
                  pwdata[`TZM_FLAG_RAIL_BIT])
            flag_reg[`TZM_FLAG_RAIL_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tempZoneIrq        <= 1'b0;
         railConfigErrorIrq <= 1'b0;
      end
      else
      begin
         tempZoneIrq        <= flag_reg[`TZM_FLAG_ZONE_BIT] &&
                               mask_reg[`TZM_FLAG_ZONE_BIT];
         railConfigErrorIrq <= flag_reg[`TZM_FLAG_RAIL_BIT] &&
                               mask_reg[`TZM_FLAG_RAIL_BIT];
      end
   end

endmodule

// ---- verilog/tzm_sync.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes only when stages 2 and 3
// agree.
`timescale 1ns/10ps
module tzm_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             core_clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;
   logic [WIDTH-1:0] differ;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
      end
      else
      begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   assign differ = stage2_reg ^ stage3_reg;

   // Hold the last agreed value while the two stages disagree
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         syncOut <= '0;
      else
         syncOut <= (stage3_reg & ~differ) | (syncOut & differ);
   end

endmodule
